// ---- rtl/cbr_clip_box.sv ----
// clip box register unit: window, viewport, instance and save registers,
// half, full and relative loads, overlap flag and box composition
// assumes an apb master on pclk and a sequencer sampling the flag outputs
//
// Function
// - window, viewport and instance each hold left, right, bottom, top.
// - window: page region shown; viewport: screen area; instance: symbol.
// - in 2d the save register holds one point as x, x, y, y.
// - in 3d the save register holds x, y and z values of one point.
// - each rectangle loads as low half, high half or full vector.
// - absolute half load: left data half to x edge, right half to y edge.
// - a relative half load writes the data plus the save point.
// - an instance write clears the overlap flag, then sets it on overlap.
// - the flag feeds a conditional jump taken when there is no overlap.
// - box composes two rectangle mappings into window and viewport.
// - composite: old window-to-viewport after definition-to-instance.
// - size-absolute box defines minus s to plus s in x and y.
// - window and viewport can be pushed and later restored.
// - the save register takes the latest addressed point, except that a box in 3d and a size-absolute box leave it unchanged.
// - a full load takes two new components and two from the save point.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
module cbr_clip_box (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sequencer side
  input wire logic overlap_test_select,
  output logic area_overlap_flag,
  output logic jump_on_flag,
  // interrupt
  output logic irq
);
  import cbr_pkg::*;

  cbr_regs_t r_reg;
  cbr_regs_t r_next;

  // ************************************************************
  // box mapping, one lane per component
  // ************************************************************
  cbr_vec_t mapped;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_map
      localparam int LO = (k / 2) * 2;
      logic signed [16:0] wspan;
      logic signed [16:0] vspan;
      logic signed [16:0] off;
      logic signed [33:0] prod;
      logic signed [33:0] quot;
      assign wspan = 17'(signed'(r_reg.win[LO + 1])) -
                     17'(signed'(r_reg.win[LO]));
      assign vspan = 17'(signed'(r_reg.view[LO + 1])) -
                     17'(signed'(r_reg.view[LO]));
      assign off = 17'(signed'(r_reg.symbol_area_full_rect[k])) -
                   17'(signed'(r_reg.win[LO]));
      assign prod = 34'(off * vspan);
      // a zero-width window would divide by zero; collapse onto its edge
      assign quot = (wspan == 17'sh00000) ? 34'sh0 : prod / 34'(wspan);
      // old mapping applied to instance edge
      assign mapped[k] = 16'(signed'(r_reg.view[LO]) + 16'(quot));
    end
  endgenerate

  // ************************************************************
  // next state
  // ************************************************************
  logic acc;
  logic wr;
  logic busy;
  logic [7:0] cmd;
  logic rel;
  cbr_tgt_t tgt;
  cbr_op_t op;
  logic [15:0] dx;
  logic [15:0] dy;
  logic [15:0] px;
  logic [15:0] py;
  logic [15:0] sx;
  logic [15:0] sy;
  logic ovl;
  logic [31:0] rdata;
  logic known;

  always_comb begin
    r_next = r_reg;
    acc = psel && penable && r_reg.pready;
    wr = acc && pwrite;
    busy = (r_reg.state != CBR_IDLE);
    cmd = pwdata[7:0];
    rel = cmd[`CBR_CMD_REL_BIT];
    tgt = cbr_tgt_t'(cmd[`CBR_CMD_TGT_LSB +: 4]);
    op = cbr_op_t'(cmd[`CBR_CMD_OP_LSB +: 3]);
    dx = r_reg.data0[31:16];
    dy = r_reg.data0[15:0];
    sx = r_reg.save[0];
    sy = r_reg.three_d ? r_reg.save[1] : r_reg.save[2];
    // relative forms add the save point
    px = rel ? 16'(sx + dx) : dx;
    py = rel ? 16'(sy + dy) : dy;
    // symbol area against the shown page region
    ovl = (signed'(r_reg.symbol_area_full_rect[0]) <= signed'(r_reg.win[1])) &&
          (signed'(r_reg.symbol_area_full_rect[1]) >= signed'(r_reg.win[0])) &&
          (signed'(r_reg.symbol_area_full_rect[2]) <= signed'(r_reg.win[3])) &&
          (signed'(r_reg.symbol_area_full_rect[3]) >= signed'(r_reg.win[2]));
    known = 1'b1;
    rdata = 32'h00000000;

    // two-phase access: pready rises one cycle into the access phase
    r_next.pready = psel && penable && !r_reg.pready;
    r_next.pslverr = 1'b0;

    // ************************************************************
    // address decode
    // ************************************************************
    if (paddr == `CBR_CTRL_OFS) begin
      rdata[`CBR_CTRL_3D_BIT] = r_reg.three_d;
    end else if (paddr == `CBR_DATA0_OFS) begin
      rdata = r_reg.data0;
    end else if (paddr == `CBR_DATA1_OFS) begin
      rdata = r_reg.data1;
    end else if (paddr == `CBR_CMD_OFS) begin
      rdata = 32'h00000000;
    end else if (paddr == `CBR_STATUS_OFS) begin
      rdata[`CBR_ST_BUSY_BIT] = busy;
      rdata[`CBR_ST_FLAG_BIT] = r_reg.flag;
    end else if (paddr == `CBR_IRQ_STS_OFS) begin
      rdata[1:0] = r_reg.irq_sts;
    end else if (paddr == `CBR_IRQ_EN_OFS) begin
      rdata[1:0] = r_reg.irq_en;
    end else if (paddr == `CBR_IRQ_CLR_OFS) begin
      rdata = 32'h00000000;
    // four edges read back as two words
    end else if (paddr == `CBR_WIN_LR_OFS) begin
      rdata = {r_reg.win[0], r_reg.win[1]};
    end else if (paddr == `CBR_WIN_BT_OFS) begin
      rdata = {r_reg.win[2], r_reg.win[3]};
    end else if (paddr == `CBR_VIEW_LR_OFS) begin
      rdata = {r_reg.view[0], r_reg.view[1]};
    end else if (paddr == `CBR_VIEW_BT_OFS) begin
      rdata = {r_reg.view[2], r_reg.view[3]};
    end else if (paddr == `CBR_SYMBOL_AREA_FULL_RECT_LR_OFS) begin
      rdata = {r_reg.symbol_area_full_rect[0], r_reg.symbol_area_full_rect[1]};
    end else if (paddr == `CBR_SYMBOL_AREA_FULL_RECT_BT_OFS) begin
      rdata = {r_reg.symbol_area_full_rect[2], r_reg.symbol_area_full_rect[3]};
    end else if (paddr == `CBR_SAVE_01_OFS) begin
      rdata = {r_reg.save[0], r_reg.save[1]};
    end else if (paddr == `CBR_SAVE_23_OFS) begin
      rdata = {r_reg.save[2], r_reg.save[3]};
    end else begin
      known = 1'b0;
    end
    if (psel && penable && !r_reg.pready) begin
      r_next.prdata = pwrite ? 32'h00000000 : rdata;
      // commands while busy are refused rather than queued
      r_next.pslverr = !known ||
        (pwrite && busy && paddr == `CBR_CMD_OFS);
    end

    // ************************************************************
    // sequencing
    // ************************************************************
    case (r_reg.state)
      CBR_EVAL: begin
        // flag set only when the new instance meets the window
        r_next.flag = ovl;
        if (ovl) begin
          r_next.irq_sts[`CBR_IRQ_OVL_BIT] = 1'b1;
        end
        r_next.irq_sts[`CBR_IRQ_DONE_BIT] = 1'b1;
        r_next.state = CBR_IDLE;
      end
      CBR_BOX: begin
        // window takes the definition, viewport its screen image
        r_next.win = r_reg.defn;
        r_next.view = mapped;
        r_next.irq_sts[`CBR_IRQ_DONE_BIT] = 1'b1;
        r_next.state = CBR_IDLE;
      end
      default: begin
        r_next.state = CBR_IDLE;
      end
    endcase

    // ************************************************************
    // register writes
    // ************************************************************
    if (wr && paddr == `CBR_CTRL_OFS) begin
      r_next.three_d = pwdata[`CBR_CTRL_3D_BIT];
    end
    if (wr && paddr == `CBR_DATA0_OFS) begin
      r_next.data0 = pwdata;
    end
    if (wr && paddr == `CBR_DATA1_OFS) begin
      r_next.data1 = pwdata;
    end
    if (wr && paddr == `CBR_IRQ_EN_OFS) begin
      r_next.irq_en = pwdata[1:0];
    end
    if (wr && paddr == `CBR_IRQ_CLR_OFS) begin
      // a clear never hides an event of the same cycle
      r_next.irq_sts = r_reg.irq_sts & ~pwdata[1:0];
      if (r_reg.state == CBR_EVAL) begin
        r_next.irq_sts[`CBR_IRQ_OVL_BIT] =
          r_next.irq_sts[`CBR_IRQ_OVL_BIT] | ovl;
      end
      if (busy) begin
        r_next.irq_sts[`CBR_IRQ_DONE_BIT] = 1'b1;
      end
    end
    // a command is only taken when idle
    if (wr && paddr == `CBR_CMD_OFS && !busy) begin
      r_next.irq_sts[`CBR_IRQ_DONE_BIT] = 1'b1;
      case (op)
        CBR_OP_LOAD: begin
          case (tgt)
            // left data half to x edge, right half to y edge
            CBR_WIN_LO: begin
              r_next.win[0] = px;
              r_next.win[2] = py;
            end
            CBR_WIN_HI: begin
              r_next.win[1] = px;
              r_next.win[3] = py;
            end
            CBR_VIEW_LO: begin
              r_next.view[0] = px;
              r_next.view[2] = py;
            end
            CBR_VIEW_HI: begin
              r_next.view[1] = px;
              r_next.view[3] = py;
            end
            CBR_SYMBOL_AREA_FULL_RECT_LO: begin
              r_next.symbol_area_full_rect[0] = px;
              r_next.symbol_area_full_rect[2] = py;
            end
            CBR_SYMBOL_AREA_FULL_RECT_HI: begin
              r_next.symbol_area_full_rect[1] = px;
              r_next.symbol_area_full_rect[3] = py;
            end
            // invisible line from save point to new point
            CBR_WIN_FULL: begin
              r_next.win = {py, sy, px, sx};
            end
            CBR_VIEW_FULL: begin
              r_next.view = {py, sy, px, sx};
            end
            CBR_SYMBOL_AREA_FULL_RECT_FULL: begin
              r_next.symbol_area_full_rect = {py, sy, px, sx};
            end
            default: begin
            end
          endcase
          // clear now, evaluate on the settled rectangle
          if (tgt == CBR_SYMBOL_AREA_FULL_RECT_LO || tgt == CBR_SYMBOL_AREA_FULL_RECT_HI ||
              tgt == CBR_SYMBOL_AREA_FULL_RECT_FULL) begin
            r_next.flag = 1'b0;
            r_next.irq_sts[`CBR_IRQ_DONE_BIT] = r_reg.irq_sts[0];
            r_next.state = CBR_EVAL;
          end
          if (r_reg.three_d) begin
            // x, y, then z from the second word
            r_next.save = {r_reg.data1[15:0], r_reg.data1[31:16], py, px};
          end else begin
            r_next.save = {py, py, px, px};
          end
        end
        CBR_OP_BOX: begin
          // definition from save point to new point
          r_next.defn = {py, sy, px, sx};
          r_next.save = r_reg.three_d ? r_reg.save : {py, py, px, px};
          r_next.irq_sts[`CBR_IRQ_DONE_BIT] = r_reg.irq_sts[0];
          r_next.state = CBR_BOX;
        end
        CBR_OP_BOX_SA: begin
          r_next.defn = {dy, 16'(-dy), dx, 16'(-dx)};
          r_next.irq_sts[`CBR_IRQ_DONE_BIT] = r_reg.irq_sts[0];
          r_next.state = CBR_BOX;
        end
        CBR_OP_PUSH: begin
          // keep the old mapping for a later restore
          r_next.push_win = r_reg.win;
          r_next.push_view = r_reg.view;
        end
        CBR_OP_RESTORE: begin
          r_next.win = r_reg.push_win;
          r_next.view = r_reg.push_view;
        end
        default: begin
        end
      endcase
    end

    // ************************************************************
    // flag and interrupt outputs
    // ************************************************************
    // jump taken when the test is selected and nothing overlaps
    r_next.jump = overlap_test_select && !r_next.flag &&
                  (r_next.state == CBR_IDLE);
    r_next.irq = |(r_next.irq_sts & r_next.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{
        win: {4{`CBR_COMP_RST}}, view: {4{`CBR_COMP_RST}},
        symbol_area_full_rect: {4{`CBR_COMP_RST}}, save: {4{`CBR_COMP_RST}},
        push_win: {4{`CBR_COMP_RST}}, push_view: {4{`CBR_COMP_RST}},
        defn: {4{`CBR_COMP_RST}}, state: CBR_IDLE, three_d: 1'b0,
        data0: 32'h00000000, data1: 32'h00000000, flag: 1'b0,
        irq_sts: 2'h0, irq_en: 2'h0, irq: 1'b0, jump: 1'b0,
        prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign area_overlap_flag = r_reg.flag;
  assign jump_on_flag = r_reg.jump;
  assign irq = r_reg.irq;
endmodule : cbr_clip_box
`default_nettype wire

// ---- rtl/cbr_regs.svh ----
// register offsets, field positions and reset values of the clip box unit
// assumes byte addressing on a 32-bit apb bus
`ifndef CBR_REGS_SVH
`define CBR_REGS_SVH
`define CBR_CTRL_OFS     8'h00
`define CBR_DATA0_OFS    8'h04
`define CBR_DATA1_OFS    8'h08
`define CBR_CMD_OFS      8'h0c
`define CBR_STATUS_OFS   8'h10
`define CBR_IRQ_STS_OFS  8'h14
`define CBR_IRQ_EN_OFS   8'h18
`define CBR_IRQ_CLR_OFS  8'h1c
`define CBR_WIN_LR_OFS   8'h20
`define CBR_WIN_BT_OFS   8'h24
`define CBR_VIEW_LR_OFS  8'h28
`define CBR_VIEW_BT_OFS  8'h2c
`define CBR_SYMBOL_AREA_FULL_RECT_LR_OFS  8'h30
`define CBR_SYMBOL_AREA_FULL_RECT_BT_OFS  8'h34
`define CBR_SAVE_01_OFS  8'h38
`define CBR_SAVE_23_OFS  8'h3c
`define CBR_CTRL_3D_BIT  0
`define CBR_CMD_TGT_LSB  0
`define CBR_CMD_REL_BIT  4
`define CBR_CMD_OP_LSB   5
`define CBR_ST_BUSY_BIT  0
`define CBR_ST_FLAG_BIT  1
`define CBR_IRQ_DONE_BIT 0
`define CBR_IRQ_OVL_BIT  1
`define CBR_COMP_RST     16'h0000
`endif

// ---- rtl/cbr_pkg.sv ----
// types shared by the clip box unit
// assumes the constants header is included where offsets are needed
`default_nettype none
package cbr_pkg;
  typedef logic signed [15:0] cbr_comp_t;
  typedef logic [3:0][15:0] cbr_vec_t;
  // load targets, component order is left, right, bottom, top
  typedef enum logic [3:0] {
    CBR_WIN_LO = 4'h0, CBR_WIN_HI = 4'h1, CBR_VIEW_LO = 4'h2,
    CBR_VIEW_HI = 4'h3, CBR_SYMBOL_AREA_FULL_RECT_LO = 4'h4, CBR_SYMBOL_AREA_FULL_RECT_HI = 4'h5,
    CBR_WIN_FULL = 4'h6, CBR_VIEW_FULL = 4'h7, CBR_SYMBOL_AREA_FULL_RECT_FULL = 4'h8,
    CBR_SAVE = 4'h9
  } cbr_tgt_t;
  typedef enum logic [2:0] {
    CBR_OP_LOAD = 3'h0, CBR_OP_BOX = 3'h1, CBR_OP_BOX_SA = 3'h2,
    CBR_OP_PUSH = 3'h3, CBR_OP_RESTORE = 3'h4
  } cbr_op_t;
  typedef enum logic [2:0] {
    CBR_IDLE = 3'b001, CBR_EVAL = 3'b010, CBR_BOX = 3'b100
  } cbr_state_t;
  typedef struct packed {
    cbr_vec_t win;
    cbr_vec_t view;
    cbr_vec_t symbol_area_full_rect;
    cbr_vec_t save;
    cbr_vec_t push_win;
    cbr_vec_t push_view;
    cbr_vec_t defn;
    cbr_state_t state;
    logic three_d;
    logic [31:0] data0;
    logic [31:0] data1;
    logic flag;
    logic [1:0] irq_sts;
    logic [1:0] irq_en;
    logic irq;
    logic jump;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cbr_regs_t;
endpackage : cbr_pkg
`default_nettype wire

// ---- verif/cbr_clip_box_asserts.sv ----
// port checker of the clip box unit
// assumes binding into cbr_clip_box, one pclk domain
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
module cbr_clip_box_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // sequencer
  input wire logic overlap_test_select,
  input wire logic area_overlap_flag,
  input wire logic jump_on_flag
);
  logic cmdw;
  logic [2:0] quiet;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign cmdw = psel && penable && pready && pwrite &&
    paddr == `CBR_CMD_OFS;
  // cycles since a command, so the unit is surely idle at 4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet <= 3'h0;
    else if (cmdw) quiet <= 3'h0;
    else if (quiet != 3'h4) quiet <= quiet + 3'h1;
  end
  // ***
  // port relations
  // ***
  a_ready_wait:
    assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  a_ready_once:
    assert property (pready |=> !pready) else $error("ready too long");
  a_ready_phase:
    assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_cause:
    assert property (pslverr |-> pready && (cmdw ||
      paddr > `CBR_SAVE_23_OFS || paddr[1:0] != 2'b00))
    else $error("error without cause");
  a_flag_cause:
    assert property ($changed(area_overlap_flag) |->
      $past(cmdw) || $past(cmdw, 2)) else $error("flag moved alone");
  a_jump_cause:
    assert property (jump_on_flag |-> $past(overlap_test_select)
      && !$past(area_overlap_flag)) else $error("jump without cause");
  a_jump_take:
    assert property (quiet == 3'h4 && overlap_test_select &&
      !area_overlap_flag |=> jump_on_flag) else $error("jump missing");
  a_select_drop:
    assert property ($fell(overlap_test_select) |=> !jump_on_flag)
    else $error("jump after select");
endmodule : cbr_clip_box_asserts
bind cbr_clip_box cbr_clip_box_asserts cbr_clip_box_asserts_symbol_area_full_rect (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .overlap_test_select(overlap_test_select),
  .area_overlap_flag(area_overlap_flag), .jump_on_flag(jump_on_flag));
`default_nettype wire

// ---- verif/cbr_seq_model.sv ----
// sequencer model: asks for the overlap jump test, records the jump
// assumes the unit's flag ports on the shared pclk
`timescale 1ns/1ps
`default_nettype none
module cbr_seq_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench side
  input wire logic ask,
  output logic jumped,
  output logic done,
  // unit side
  input wire logic area_overlap_flag,
  input wire logic jump_on_flag,
  output logic overlap_test_select
);
  logic [2:0] cnt;
  // ***
  // jump test window
  // ***
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      overlap_test_select <= 1'b0;
      jumped <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (ask) begin
        cnt <= 3'h4;
        overlap_test_select <= 1'b1;
        jumped <= 1'b0;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
        jumped <= jumped | jump_on_flag;
        overlap_test_select <= cnt != 3'h1;
        done <= cnt == 3'h1;
      end
    end
  end
endmodule : cbr_seq_model
`default_nettype wire

// ---- verif/clip_box_register_unit_bench.sv ----
// self-checking bench of the clip box unit over apb
// assumes design, checker and sequencer model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cbr_regs.svh"
module clip_box_register_unit_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ask = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sel, flag, jump, irq, jumped, sdone;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  int m[4][4];
  int pw[4], pv[4], nv[4];
  int n_mismatch = 0, n_checks = 0, a, b, c, d, k;
  always #5 pclk = ~pclk;
  cbr_clip_box cbr_clip_box_symbol_area_full_rect (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overlap_test_select(sel),
    .area_overlap_flag(flag), .jump_on_flag(jump), .irq(irq));
  cbr_seq_model cbr_seq_model_symbol_area_full_rect (.pclk(pclk), .presetn(presetn),
    .ask(ask), .jumped(jumped), .done(sdone), .area_overlap_flag(flag),
    .jump_on_flag(jump), .overlap_test_select(sel));
  task check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // ***
  // apb master and result watcher
  // ***
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] dt,
    input logic [31:0] e, input logic ck, input logic er);
    exp_q.push_back({ck, er, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = exp_q.pop_front();
      check(32'(pslverr), 32'(note[32]));
      if (note[33]) check(prdata, note[31:0]);
    end
  end
  task wr(input logic [7:0] ad, input logic [31:0] dt);
    xfer(1'b1, ad, dt, 32'h0, 1'b0, 1'b0);
  endtask : wr
  task rd(input logic [7:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0, e, 1'b1, 1'b0);
  endtask : rd
  task cmd(input logic [2:0] op, input logic [3:0] t, input logic rel);
    wr(`CBR_CMD_OFS, {24'h0, op, rel, t});
  endtask : cmd
  // expected effect of a point load, then the load itself
  task ld(input int t, input logic rel, input int x, input int y);
    int px, py;
    px = x + (rel ? m[3][0] : 0);
    py = y + (rel ? m[3][2] : 0);
    if (t < 6) begin
      m[t / 2][t % 2] = px;
      m[t / 2][2 + t % 2] = py;
    end else if (t < 9) m[t - 6] = '{m[3][0], px, m[3][2], py};
    m[3] = '{px, px, py, py};
    wr(`CBR_DATA0_OFS, {16'(x), 16'(y)});
    cmd(3'h0, 4'(t), rel);
  endtask : ld
  task chk(input int n);
    for (int r = 0; r < n; r++) begin
      rd(`CBR_WIN_LR_OFS + 8'(8 * r), {16'(m[r][0]), 16'(m[r][1])});
      rd(`CBR_WIN_BT_OFS + 8'(8 * r), {16'(m[r][2]), 16'(m[r][3])});
    end
  endtask : chk
  // expected box: old mapping applied to the instance edges
  task box_exp(input int l, input int r, input int b, input int t);
    for (k = 0; k < 4; k++) begin
      nv[k] = m[1][k & 2] + (m[2][k] - m[0][k & 2]) *
        (m[1][k | 1] - m[1][k & 2]) / (m[0][k | 1] - m[0][k & 2]);
    end
    m[0] = '{l, r, b, t};
    m[1] = nv;
  endtask : box_exp
  task seq_test(input logic want);
    @(posedge pclk);
    ask <= 1'b1;
    @(posedge pclk);
    ask <= 1'b0;
    @(posedge pclk iff sdone === 1'b1);
    check(32'(jumped), 32'(want));
  endtask : seq_test
  initial begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    void'($urandom(32'hfa9d));
    m = '{default: 0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(4);
    rd(`CBR_STATUS_OFS, 32'h0);
    a = $urandom_range(100, 199);
    b = $urandom_range(100, 199);
    ld(0, 1'b0, -a, -b);
    ld(1, 1'b0, a, b);
    ld(2, 1'b0, -b, -a);
    ld(3, 1'b1, $urandom_range(200, 399), 300);
    chk(4);
    // overlapping instance: flag, masked then enabled interrupt
    c = $urandom_range(0, 50);
    ld(9, 1'b0, -c, -c);
    ld(8, 1'b0, c + 20, c + 30);
    chk(4);
    rd(`CBR_STATUS_OFS, 32'h2);
    check(32'(flag), 32'h1);
    check(32'(irq), 32'h0);
    wr(`CBR_IRQ_EN_OFS, 32'h3);
    rd(`CBR_IRQ_STS_OFS, 32'h3);
    check(32'(irq), 32'h1);
    wr(`CBR_IRQ_CLR_OFS, 32'h3);
    rd(`CBR_IRQ_STS_OFS, 32'h0);
    check(32'(irq), 32'h0);
    seq_test(1'b0);
    // full relative instance load away from the window
    ld(9, 1'b0, 500, 500);
    ld(8, 1'b1, 20, 20);
    rd(`CBR_STATUS_OFS, 32'h0);
    check(32'(flag), 32'h0);
    seq_test(1'b1);
    // box onto an overlapping instance, then restore the mapping
    ld(9, 1'b0, -20, -30);
    ld(8, 1'b0, 40, 50);
    pw = m[0];
    pv = m[1];
    cmd(3'h3, 4'h0, 1'b0);
    d = $urandom_range(1000, 2000);
    wr(`CBR_DATA0_OFS, {16'(d), 16'(d)});
    cmd(3'h2, 4'h0, 1'b0);
    box_exp(-d, d, -d, d);
    rd(`CBR_STATUS_OFS, 32'h2);
    chk(3);
    cmd(3'h4, 4'h0, 1'b0);
    m[0] = pw;
    m[1] = pv;
    chk(3);
    // half instance loads, full window and viewport loads, box to a point
    ld(4, 1'b0, -5, -6);
    ld(5, 1'b1, 10, 12);
    rd(`CBR_STATUS_OFS, 32'h2);
    ld(6, 1'b1, 20, 30);
    ld(7, 1'b0, 90, 80);
    chk(4);
    ld(9, 1'b0, -30, -40);
    wr(`CBR_DATA0_OFS, {16'(30), 16'(40)});
    cmd(3'h1, 4'h0, 1'b0);
    box_exp(-30, 30, -40, 40);
    m[3] = '{30, 30, 40, 40};
    chk(4);
    // three-dimensional save point
    wr(`CBR_CTRL_OFS, 32'h1);
    rd(`CBR_CTRL_OFS, 32'h1);
    wr(`CBR_DATA1_OFS, 32'h004d_0063);
    ld(9, 1'b0, 7, 9);
    rd(`CBR_SAVE_01_OFS, 32'h0007_0009);
    rd(`CBR_SAVE_23_OFS, 32'h004d_0063);
    xfer(1'b0, 8'h40, 32'h0, 32'h0, 1'b1, 1'b1);
    xfer(1'b1, 8'h44, 32'h5, 32'h0, 1'b0, 1'b1);
    complete_run();
  end
endmodule : clip_box_register_unit_bench
`default_nettype wire
